// *** pmrc_rail_control_regs.sv ***
`timescale 1ns/1ps
module pmrc_rail_control_regs (
    input  wire logic       CLK_IN,
    input  wire logic       NRST_IN,
    input  wire logic       SCL_IN,
    input  wire logic       SDA_IN,
    output logic            SDA_OUT,
    output logic            SDA_OE_N_OUT,
    input  wire logic       POWER_FAIL_OUT_N_IN,
    input  wire logic       FRESH_SEAL_IN,
    input  wire logic       WARM_RESET_PIN_EN_IN,
    input  wire logic       SEQ_LOAD_IN,
    input  wire logic [6:0] SEQ_ENABLES_IN,
    input  wire logic       SEQ_POWER_UP_IN,
    input  wire logic       WAKE_FROM_SUSPEND_IN,
    input  wire logic [7:0] SUSPEND_ON_IN,
    input  wire logic       GEN_PIN_A_IN,
    input  wire logic       GEN_PIN_C_IN,
    output logic            GEN_PIN_A_OUT,
    output logic            GEN_PIN_A_OE_N_OUT,
    output logic            GEN_PIN_B_OUT,
    output logic            GEN_PIN_B_OE_N_OUT,
    output logic            GEN_PIN_C_OUT,
    output logic            GEN_PIN_C_OE_N_OUT,
    output logic            WARM_RESET_OUT,
    output logic            COIN_ACQ_START_OUT,
    output logic            OFF_STATE_OUT,
    output logic [5:0]      CONV_ON_OUT,
    output logic [3:0]      SWITCH_ON_OUT,
    output logic [7:0]      CONFIG_A_OUT
);

    // ==========================================================
    // Bus slave
    pmrc_regbus_if bus ();

    pmrc_i2c_slave u_slave (
        .clk_in       (CLK_IN),
        .nrst_in      (NRST_IN),
        .scl_in       (SCL_IN),
        .sda_in       (SDA_IN),
        .sda_oe_n_out (SDA_OE_N_OUT),
        .bus          (bus.slave)
    );

    // Open-drain: the line is only ever pulled low.
    assign SDA_OUT       = 1'b0;
    assign GEN_PIN_A_OUT = 1'b0;
    assign GEN_PIN_C_OUT = 1'b0;

    // ==========================================================
    // Storage
    logic       pfsd_q, coin_q, off_q, arm_q;
    logic [7:0] arm_addr_q, flags_q, conv_q, swout_q, cfga_q;

    // A converter that the seal protects may be set but never cleared
    // while the seal is fresh.
    function automatic logic guard(input logic old_v, input logic new_v, input logic seal);
        guard = seal ? (old_v | new_v) : new_v;
    endfunction : guard

    // ==========================================================
    // Decode
    wire wr_c      = bus.wr_stb;
    wire wr_ctrl   = wr_c && bus.addr == pmrc_pkg::ADDR_CTRL;
    wire wr_key    = wr_c && bus.addr == pmrc_pkg::ADDR_KEY;
    wire is_prot   = bus.addr == pmrc_pkg::ADDR_CONV || bus.addr == pmrc_pkg::ADDR_SWOUT
                     || bus.addr == pmrc_pkg::ADDR_CFGA;
    // Unlock holds for exactly one write, and only to the named subaddress.
    wire unlock_ok = arm_q && arm_addr_q == bus.addr;
    wire wr_prot   = wr_c && is_prot && unlock_ok;
    wire wr_conv   = wr_prot && bus.addr == pmrc_pkg::ADDR_CONV;
    wire wr_swout  = wr_prot && bus.addr == pmrc_pkg::ADDR_SWOUT;
    wire wr_cfga   = wr_prot && bus.addr == pmrc_pkg::ADDR_CFGA;
    wire pf_trip   = pfsd_q && !POWER_FAIL_OUT_N_IN;

    // ==========================================================
    // Converter enables: shutdown over sequencer over host
    wire [7:0] conv_host = wr_conv ? (bus.wdata & pmrc_pkg::MASK_CONV) : conv_q;
    wire [7:0] conv_seq  = SEQ_LOAD_IN ? {conv_host[7:5], SEQ_ENABLES_IN[4:0]} : conv_host;
    wire [7:0] conv_off  = pf_trip ? 8'h00 : conv_seq;
    wire       bkp_a_d   = guard(conv_q[pmrc_pkg::CONV_BKP_A], conv_off[pmrc_pkg::CONV_BKP_A],
                                 FRESH_SEAL_IN);
    wire       bkp_b_d   = guard(conv_q[pmrc_pkg::CONV_BKP_B], conv_off[pmrc_pkg::CONV_BKP_B],
                                 FRESH_SEAL_IN);
    wire [7:0] conv_d    = {2'b00, bkp_b_d, bkp_a_d, conv_off[3:0]};

    // Switch and pin register: sequencer owns linreg and first switch.
    wire [7:0] sw_host   = wr_swout ? (bus.wdata & pmrc_pkg::MASK_SWOUT) : swout_q;
    // The sequencer word puts the linear regulator above the first switch, the register below it.
    wire [7:0] sw_seq    = SEQ_LOAD_IN ? {sw_host[7:2], SEQ_ENABLES_IN[5], SEQ_ENABLES_IN[6]} : sw_host;
    wire [7:0] swout_d   = pf_trip ? {sw_seq[7:4], 4'h0} : sw_seq;

    wire [7:0] cfga_d    = wr_cfga ? (bus.wdata & pmrc_pkg::MASK_CFGA) : cfga_q;

    // ==========================================================
    // Read mux; the key register and unmapped subaddresses read zero.
    wire [7:0] rd_word =
        bus.addr == pmrc_pkg::ADDR_CTRL  ? {6'h00, pfsd_q, coin_q} :
        bus.addr == pmrc_pkg::ADDR_FLAGS ? flags_q :
        bus.addr == pmrc_pkg::ADDR_CONV  ? conv_q :
        bus.addr == pmrc_pkg::ADDR_SWOUT ? swout_q :
        bus.addr == pmrc_pkg::ADDR_CFGA  ? cfga_q :
        pmrc_pkg::READ_ZERO;

    // ==========================================================
    // Pin control
    wire insel     = cfga_q[pmrc_pkg::CFG_INSEL];
    wire pushpull  = cfga_q[pmrc_pkg::CFG_BUFTYPE];
    wire pin_b_src = insel ? GEN_PIN_A_IN : swout_q[pmrc_pkg::SW_PIN_B];
    wire pin_a_oen = insel | swout_q[pmrc_pkg::SW_PIN_A];
    wire pin_b_oen = pushpull ? 1'b0 : pin_b_src;
    wire pin_c_oen = WARM_RESET_PIN_EN_IN | swout_q[pmrc_pkg::SW_PIN_C];

    // ==========================================================
    // Registers
    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            {pfsd_q, coin_q} <= pmrc_pkg::RST_CTRL[1:0];
            off_q <= 1'b0;
            arm_q <= 1'b0;
            arm_addr_q <= 8'h00;
            flags_q <= pmrc_pkg::RST_FLAGS;
            conv_q <= pmrc_pkg::RST_CONV;
            swout_q <= pmrc_pkg::RST_SWOUT;
            cfga_q <= pmrc_pkg::RST_CFGA;
            bus.rdata <= pmrc_pkg::READ_ZERO;
            COIN_ACQ_START_OUT <= 1'b0;
        end else begin
            conv_q <= conv_d;
            swout_q <= swout_d;
            cfga_q <= cfga_d;
            if (wr_ctrl) begin
                pfsd_q <= bus.wdata[pmrc_pkg::CTRL_PFSD];
            end
            // A fresh write of 1 wins over the self-clear of the last one.
            coin_q <= wr_ctrl & bus.wdata[pmrc_pkg::CTRL_COIN];
            COIN_ACQ_START_OUT <= coin_q;
            if (pf_trip) begin
                off_q <= 1'b1;
            end else if (SEQ_POWER_UP_IN) begin
                off_q <= 1'b0;
            end
            if (wr_key) begin
                arm_q <= 1'b1;
                arm_addr_q <= bus.wdata ^ pmrc_pkg::UNLOCK_KEY_VALUE;
            end else if (wr_c) begin
                arm_q <= 1'b0;
            end
            if (SEQ_POWER_UP_IN) begin
                flags_q <= WAKE_FROM_SUSPEND_IN ? SUSPEND_ON_IN : 8'h00;
            end
            if (bus.rd_stb) begin
                bus.rdata <= rd_word;
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            GEN_PIN_A_OE_N_OUT <= 1'b1;
            GEN_PIN_B_OE_N_OUT <= 1'b1;
            GEN_PIN_B_OUT <= 1'b0;
            GEN_PIN_C_OE_N_OUT <= 1'b1;
            WARM_RESET_OUT <= 1'b0;
        end else begin
            GEN_PIN_A_OE_N_OUT <= pin_a_oen;
            GEN_PIN_B_OE_N_OUT <= pin_b_oen;
            GEN_PIN_B_OUT <= pushpull & pin_b_src;
            GEN_PIN_C_OE_N_OUT <= pin_c_oen;
            WARM_RESET_OUT <= WARM_RESET_PIN_EN_IN & ~GEN_PIN_C_IN;
        end
    end

    assign OFF_STATE_OUT = off_q;
    assign CONV_ON_OUT   = conv_q[5:0];
    assign SWITCH_ON_OUT = swout_q[3:0];
    assign CONFIG_A_OUT  = cfga_q;

    // ==========================================================
    // Assertions
    property p_pf_shutdown;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        pf_trip |=> OFF_STATE_OUT && CONV_ON_OUT[3:0] == 4'h0 && SWITCH_ON_OUT == 4'h0;
    endproperty
    a_pf_shutdown: assert property (p_pf_shutdown) else $error("rails not shut on power fail");

    property p_pf_ignored;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        $rose(OFF_STATE_OUT) |-> $past(pfsd_q) && !$past(POWER_FAIL_OUT_N_IN);
    endproperty
    a_pf_ignored: assert property (p_pf_ignored) else $error("off state entered without enable");

    property p_coin_pulse;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        wr_ctrl && bus.wdata[pmrc_pkg::CTRL_COIN] |=> coin_q ##1 COIN_ACQ_START_OUT;
    endproperty
    a_coin_pulse: assert property (p_coin_pulse) else $error("coin start not pulsed");

    property p_flags_load;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        SEQ_POWER_UP_IN && !WAKE_FROM_SUSPEND_IN |=> flags_q == 8'h00;
    endproperty
    a_flags_load: assert property (p_flags_load) else $error("flags set after cold power-up");

    property p_flags_ro;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        !SEQ_POWER_UP_IN |=> $stable(flags_q);
    endproperty
    a_flags_ro: assert property (p_flags_ro) else $error("flags changed without power-up");

    property p_key_zero;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        bus.rd_stb && bus.addr == pmrc_pkg::ADDR_KEY |=> bus.rdata == 8'h00;
    endproperty
    a_key_zero: assert property (p_key_zero) else $error("key register read nonzero");

    property p_seal_b;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        FRESH_SEAL_IN && conv_q[pmrc_pkg::CONV_BKP_B] |=> conv_q[pmrc_pkg::CONV_BKP_B];
    endproperty
    a_seal_b: assert property (p_seal_b) else $error("sealed converter disabled");

    property p_seq_load;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        SEQ_LOAD_IN && !pf_trip |=> conv_q[3:0] == $past(SEQ_ENABLES_IN[3:0])
                                    && swout_q[1:0] == {$past(SEQ_ENABLES_IN[5]), $past(SEQ_ENABLES_IN[6])};
    endproperty
    a_seq_load: assert property (p_seq_load) else $error("sequencer load not applied");

    property p_locked;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        wr_c && bus.addr == pmrc_pkg::ADDR_CFGA && !arm_q |=> $stable(cfga_q);
    endproperty
    a_locked: assert property (p_locked) else $error("locked write took effect");

    property p_pin_c;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        WARM_RESET_PIN_EN_IN [*2] |-> GEN_PIN_C_OE_N_OUT;
    endproperty
    a_pin_c: assert property (p_pin_c) else $error("third pin driven in warm-reset mode");

    property p_seal_a;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        FRESH_SEAL_IN && conv_q[pmrc_pkg::CONV_BKP_A] |=> conv_q[pmrc_pkg::CONV_BKP_A];
    endproperty
    a_seal_a: assert property (p_seal_a) else $error("sealed fifth converter disabled");

    property p_pf_hold;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        !pfsd_q && !SEQ_POWER_UP_IN |=> $stable(OFF_STATE_OUT);
    endproperty
    a_pf_hold: assert property (p_pf_hold) else $error("power state moved with shutdown off");

    property p_coin_clear;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        coin_q && !wr_ctrl |=> !coin_q;
    endproperty
    a_coin_clear: assert property (p_coin_clear) else $error("coin bit did not self-clear");

    property p_unlock_once;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        wr_c && !wr_key |=> !arm_q;
    endproperty
    a_unlock_once: assert property (p_unlock_once) else $error("unlock outlived one write");

    property p_pin_a;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        !cfga_q[pmrc_pkg::CFG_INSEL] && !swout_q[pmrc_pkg::SW_PIN_A] |=> !GEN_PIN_A_OE_N_OUT;
    endproperty
    a_pin_a: assert property (p_pin_a) else $error("first pin not driven low");

    property p_pin_b_sel;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        cfga_q[pmrc_pkg::CFG_INSEL] && !cfga_q[pmrc_pkg::CFG_BUFTYPE] |=> GEN_PIN_B_OE_N_OUT == $past(GEN_PIN_A_IN);
    endproperty
    a_pin_b_sel: assert property (p_pin_b_sel) else $error("second pin ignores first pin input");

    property p_warm_rst;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        WARM_RESET_PIN_EN_IN && !GEN_PIN_C_IN |=> WARM_RESET_OUT;
    endproperty
    a_warm_rst: assert property (p_warm_rst) else $error("warm reset not passed on");

endmodule : pmrc_rail_control_regs

// *** pmrc_pkg.sv ***
package pmrc_pkg;

    // ==========================================================
    // Register subaddresses
    localparam logic [7:0] ADDR_CTRL  = 8'h06;
    localparam logic [7:0] ADDR_FLAGS = 8'h07;
    localparam logic [7:0] ADDR_KEY   = 8'h10;
    localparam logic [7:0] ADDR_CONV  = 8'h11;
    localparam logic [7:0] ADDR_SWOUT = 8'h12;
    localparam logic [7:0] ADDR_CFGA  = 8'h13;

    // ==========================================================
    // Reset values and writable masks
    localparam logic [7:0] RST_CTRL   = 8'h00;
    localparam logic [7:0] RST_FLAGS  = 8'h00;
    localparam logic [7:0] RST_CONV   = 8'h00;
    localparam logic [7:0] RST_SWOUT  = 8'h00;
    localparam logic [7:0] RST_CFGA   = 8'h08;
    localparam logic [7:0] MASK_CONV  = 8'h3F;
    localparam logic [7:0] MASK_SWOUT = 8'h7F;
    localparam logic [7:0] MASK_CFGA  = 8'hFB;
    localparam logic [7:0] READ_ZERO  = 8'h00;

    // ==========================================================
    // Field positions
    localparam int CTRL_COIN   = 0;
    localparam int CTRL_PFSD   = 1;
    localparam int CONV_BKP_A  = 4;
    localparam int CONV_BKP_B  = 5;
    localparam int SW_LINREG   = 0;
    localparam int SW_PIN_A    = 4;
    localparam int SW_PIN_B    = 5;
    localparam int SW_PIN_C    = 6;
    localparam int CFG_INSEL   = 5;
    localparam int CFG_BUFTYPE = 6;

    // Value is arbitrary; it only salts the unlock write.
    localparam logic [7:0] UNLOCK_KEY_VALUE = 8'h5A;
    // Value is arbitrary; bus address of this slave.
    localparam logic [6:0] DEV_ADDR         = 7'h2A;
    localparam logic [3:0] I2C_BITS         = 4'h8;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_AACK = 7'h04,
        ST_WR   = 7'h08,
        ST_WACK = 7'h10,
        ST_RD   = 7'h20,
        ST_RACK = 7'h40
    } pmrc_i2c_e;

endpackage : pmrc_pkg

// *** pmrc_regbus_if.sv ***
`timescale 1ns/1ps
interface pmrc_regbus_if;
    logic       wr_stb;
    logic       rd_stb;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport slave (output wr_stb, output rd_stb, output addr, output wdata, input rdata);
    modport regs  (input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface : pmrc_regbus_if

// *** pmrc_i2c_slave.sv ***
`timescale 1ns/1ps
module pmrc_i2c_slave (
    input  wire logic     clk_in,
    input  wire logic     nrst_in,
    input  wire logic     scl_in,
    input  wire logic     sda_in,
    output logic          sda_oe_n_out,
    pmrc_regbus_if.slave  bus
);
    pmrc_pkg::pmrc_i2c_e state_q;
    logic       scl_q, sda_q, rw_q, sub_q, mack_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;

    wire scl_rise = scl_in & ~scl_q;
    wire scl_fall = ~scl_in & scl_q;
    wire start_c  = scl_in & scl_q & sda_q & ~sda_in;
    wire stop_c   = scl_in & scl_q & ~sda_q & sda_in;
    wire full_c   = (cnt_q == pmrc_pkg::I2C_BITS);

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            state_q <= pmrc_pkg::ST_IDLE;
            {scl_q, sda_q} <= 2'b11;
            {rw_q, sub_q, mack_q, sda_oe_n_out} <= 4'b0001;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            bus.wr_stb <= 1'b0;
            bus.rd_stb <= 1'b0;
            bus.addr <= 8'h00;
            bus.wdata <= 8'h00;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
            bus.wr_stb <= 1'b0;
            bus.rd_stb <= 1'b0;
            // The subaddress steps once a write has been strobed.
            if (bus.wr_stb) begin
                bus.addr <= bus.addr + 8'h01;
            end
            if (start_c) begin
                state_q <= pmrc_pkg::ST_ADDR;
                cnt_q <= 4'h0;
                sub_q <= 1'b0;
                sda_oe_n_out <= 1'b1;
            end else if (stop_c) begin
                state_q <= pmrc_pkg::ST_IDLE;
                sda_oe_n_out <= 1'b1;
            end else if (scl_rise) begin
                case (state_q)
                    pmrc_pkg::ST_ADDR, pmrc_pkg::ST_WR: begin
                        sh_q <= {sh_q[6:0], sda_in};
                        cnt_q <= cnt_q + 4'h1;
                    end
                    pmrc_pkg::ST_RACK: begin
                        mack_q <= ~sda_in;
                        if (!sda_in) begin
                            bus.addr <= bus.addr + 8'h01;
                            bus.rd_stb <= 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (scl_fall) begin
                case (state_q)
                    pmrc_pkg::ST_ADDR: begin
                        if (full_c && sh_q[7:1] == pmrc_pkg::DEV_ADDR) begin
                            state_q <= pmrc_pkg::ST_AACK;
                            rw_q <= sh_q[0];
                            bus.rd_stb <= sh_q[0];
                            sda_oe_n_out <= 1'b0;
                        end else if (full_c) begin
                            state_q <= pmrc_pkg::ST_IDLE;
                        end
                    end
                    pmrc_pkg::ST_WR: begin
                        if (full_c) begin
                            state_q <= pmrc_pkg::ST_WACK;
                            sda_oe_n_out <= 1'b0;
                            sub_q <= 1'b1;
                            if (sub_q) begin
                                bus.wr_stb <= 1'b1;
                                bus.wdata <= sh_q;
                            end else begin
                                bus.addr <= sh_q;
                            end
                        end
                    end
                    pmrc_pkg::ST_WACK: begin
                        state_q <= pmrc_pkg::ST_WR;
                        cnt_q <= 4'h0;
                        sda_oe_n_out <= 1'b1;
                    end
                    pmrc_pkg::ST_AACK, pmrc_pkg::ST_RACK: begin
                        if (state_q == pmrc_pkg::ST_AACK && !rw_q) begin
                            state_q <= pmrc_pkg::ST_WR;
                            cnt_q <= 4'h0;
                            sda_oe_n_out <= 1'b1;
                        end else if (state_q == pmrc_pkg::ST_RACK && !mack_q) begin
                            state_q <= pmrc_pkg::ST_IDLE;
                        end else begin
                            state_q <= pmrc_pkg::ST_RD;
                            sda_oe_n_out <= bus.rdata[7];
                            sh_q <= {bus.rdata[6:0], 1'b0};
                            cnt_q <= 4'h1;
                        end
                    end
                    pmrc_pkg::ST_RD: begin
                        if (full_c) begin
                            state_q <= pmrc_pkg::ST_RACK;
                            sda_oe_n_out <= 1'b1;
                        end else begin
                            sda_oe_n_out <= sh_q[7];
                            sh_q <= {sh_q[6:0], 1'b0};
                            cnt_q <= cnt_q + 4'h1;
                        end
                    end
                    default: begin
                        state_q <= pmrc_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule : pmrc_i2c_slave

// *** pmrc_host_model.sv ***
`timescale 1ns/1ps
module pmrc_host_model (
    input  wire logic clk_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_low_out
);
    // ==========================================================
    // Bus master
    // Every phase spans several clocks so the slave's level sampling never misses one.
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : tick
    task automatic put_bit(input logic b, output logic r);
        tick(3);
        sda_low_out = !b;
        tick(3);
        scl_out = 1'b1;
        tick(6);
        r = sda_in;
        scl_out = 1'b0;
    endtask : put_bit
    task automatic start;
        tick(3);
        sda_low_out = 1'b0;
        scl_out = 1'b1;
        tick(6);
        sda_low_out = 1'b1;
        tick(6);
        scl_out = 1'b0;
    endtask : start
    task automatic stop;
        tick(3);
        sda_low_out = 1'b1;
        tick(3);
        scl_out = 1'b1;
        tick(6);
        sda_low_out = 1'b0;
        tick(6);
    endtask : stop
    // A read passes 8'hFF so that the slave alone drives the data bits.
    task automatic xfer(input logic [7:0] tx, input logic ab, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--)
            put_bit(tx[i], rx[i]);
        put_bit(ab, ack);
    endtask : xfer
endmodule : pmrc_host_model

// *** pmrc_rail_control_regs_test.sv ***
`timescale 1ns/1ps
module pmrc_rail_control_regs_test;
    logic       clk = 1'b0, nrst = 1'b0, pfo_n = 1'b1, seal = 1'b0, wen = 1'b0;
    logic       pup = 1'b0, wake = 1'b0, pa = 1'b1, pc = 1'b1, ack;
    logic       scl, sda_low, sda_oe_n, a_oe, b_oe, c_oe, wrst, coin, off, b_out, seq_ld = 1'b0;
    logic [7:0] son = 8'h00, cv = 8'h00, sw, cf, d, cfo;
    logic [5:0] conv;
    logic [3:0] swo;
    logic [6:0] seq_en = 7'h00;
    int         fail_count = 0, n_tests = 0, ncoin = 0, cyc = 0;
    wire        sda = !(sda_low || !sda_oe_n);
    wire        pin_a = pa & a_oe;
    wire        pin_c = pc & c_oe;
    always #4 clk = ~clk;
    pmrc_host_model u_host (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));
    pmrc_rail_control_regs u_dut (.CLK_IN(clk), .NRST_IN(nrst), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(),
        .SDA_OE_N_OUT(sda_oe_n), .POWER_FAIL_OUT_N_IN(pfo_n), .FRESH_SEAL_IN(seal),
        .WARM_RESET_PIN_EN_IN(wen), .SEQ_LOAD_IN(seq_ld), .SEQ_ENABLES_IN(seq_en), .SEQ_POWER_UP_IN(pup),
        .WAKE_FROM_SUSPEND_IN(wake), .SUSPEND_ON_IN(son), .GEN_PIN_A_IN(pin_a), .GEN_PIN_C_IN(pin_c),
        .GEN_PIN_A_OUT(), .GEN_PIN_A_OE_N_OUT(a_oe), .GEN_PIN_B_OUT(b_out), .GEN_PIN_B_OE_N_OUT(b_oe),
        .GEN_PIN_C_OUT(), .GEN_PIN_C_OE_N_OUT(c_oe), .WARM_RESET_OUT(wrst), .COIN_ACQ_START_OUT(coin),
        .OFF_STATE_OUT(off), .CONV_ON_OUT(conv), .SWITCH_ON_OUT(swo), .CONFIG_A_OUT(cfo));
    // ==========================================================
    // Checking and bus tasks
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic complete_run;
        if (fail_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic [7:0] j;
        u_host.start();
        u_host.xfer({pmrc_pkg::DEV_ADDR, 1'b0}, 1'b1, j, ack);
        u_host.xfer(a, 1'b1, j, ack);
        u_host.xfer(v, 1'b1, j, ack);
        u_host.stop();
    endtask : wr
    // The unlock write names its target, so a stray write elsewhere cannot use it.
    task automatic pw(input logic [7:0] a, input logic [7:0] v);
        wr(pmrc_pkg::ADDR_KEY, a ^ pmrc_pkg::UNLOCK_KEY_VALUE);
        wr(a, v);
    endtask : pw
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] j;
        u_host.start();
        u_host.xfer({pmrc_pkg::DEV_ADDR, 1'b0}, 1'b1, j, ack);
        check({7'h00, ack}, 8'h00);
        u_host.xfer(a, 1'b1, j, ack);
        u_host.start();
        u_host.xfer({pmrc_pkg::DEV_ADDR, 1'b1}, 1'b1, j, ack);
        u_host.xfer(8'hFF, 1'b1, j, ack);
        u_host.stop();
        check(j, exp);
    endtask : rc
    // A master acknowledge continues the read at the next subaddress.
    task automatic rb(input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1);
        logic [7:0] j;
        u_host.start();
        u_host.xfer({pmrc_pkg::DEV_ADDR, 1'b0}, 1'b1, j, ack);
        u_host.xfer(a, 1'b1, j, ack);
        u_host.start();
        u_host.xfer({pmrc_pkg::DEV_ADDR, 1'b1}, 1'b1, j, ack);
        u_host.xfer(8'hFF, 1'b0, j, ack);
        check(j, e0);
        u_host.xfer(8'hFF, 1'b1, j, ack);
        u_host.stop();
        check(j, e1);
    endtask : rb
    always @(posedge clk) begin
        if (coin === 1'b1)
            ncoin++;
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            complete_run();
        end
    end
    initial begin
        void'($urandom(73));
        repeat (12) @(posedge clk);
        #1 nrst = 1'b1;
        rc(pmrc_pkg::ADDR_CTRL, pmrc_pkg::RST_CTRL);
        rc(pmrc_pkg::ADDR_FLAGS, pmrc_pkg::RST_FLAGS);
        rc(pmrc_pkg::ADDR_CONV, pmrc_pkg::RST_CONV);
        rc(pmrc_pkg::ADDR_SWOUT, pmrc_pkg::RST_SWOUT);
        rc(pmrc_pkg::ADDR_CFGA, pmrc_pkg::RST_CFGA);
        wr(pmrc_pkg::ADDR_KEY, pmrc_pkg::ADDR_SWOUT ^ pmrc_pkg::UNLOCK_KEY_VALUE);
        rc(pmrc_pkg::ADDR_KEY, pmrc_pkg::READ_ZERO);
        wr(pmrc_pkg::ADDR_CONV, 8'hFF);
        rc(pmrc_pkg::ADDR_CONV, pmrc_pkg::RST_CONV);
        wr(pmrc_pkg::ADDR_CFGA, 8'h00);
        rc(pmrc_pkg::ADDR_CFGA, pmrc_pkg::RST_CFGA);
        seal = 1'b1;
        pw(pmrc_pkg::ADDR_CONV, 8'hFF);
        pw(pmrc_pkg::ADDR_CONV, 8'h00);
        rc(pmrc_pkg::ADDR_CONV, 8'h30);
        seal = 1'b0;
        pw(pmrc_pkg::ADDR_CONV, 8'h00);
        rc(pmrc_pkg::ADDR_CONV, 8'h00);
        for (int i = 0; i < 6; i++) begin
            {seal, wen, pa, pc, d} = 12'($urandom);
            pw(pmrc_pkg::ADDR_CONV, d);
            cv = (d & pmrc_pkg::MASK_CONV) | (seal ? cv & 8'h30 : 8'h00);
            sw = 8'($urandom);
            pw(pmrc_pkg::ADDR_SWOUT, sw);
            sw = sw & pmrc_pkg::MASK_SWOUT;
            cf = 8'($urandom);
            pw(pmrc_pkg::ADDR_CFGA, cf);
            cf = cf & pmrc_pkg::MASK_CFGA;
            rc(pmrc_pkg::ADDR_CONV, cv);
            rc(pmrc_pkg::ADDR_SWOUT, sw);
            rc(pmrc_pkg::ADDR_CFGA, cf);
            check({2'b00, conv}, cv);
            check({4'h0, swo}, {4'h0, sw[3:0]});
            check(cfo, cf);
            check({7'h00, a_oe}, {7'h00, cf[5] | sw[4]});
            check({7'h00, c_oe}, {7'h00, wen | sw[6]});
            check({7'h00, wrst}, {7'h00, wen & !pc});
            check({7'h00, b_oe}, {7'h00, !cf[6] & (cf[5] ? pa : sw[5])});
            check({7'h00, b_out}, {7'h00, cf[6] & (cf[5] ? pa : sw[5])});
        end
        seq_en = 7'($urandom);
        seq_ld = 1'b1;
        @(posedge clk);
        #1 seq_ld = 1'b0;
        cv = {2'b00, cv[5], seq_en[4] | (seal & cv[4]), seq_en[3:0]};
        sw = {sw[7:2], seq_en[5], seq_en[6]};
        rb(pmrc_pkg::ADDR_CONV, cv, sw);
        son = 8'($urandom);
        wake = 1'b1;
        pup = 1'b1;
        @(posedge clk);
        #1 pup = 1'b0;
        rc(pmrc_pkg::ADDR_FLAGS, son);
        wr(pmrc_pkg::ADDR_FLAGS, ~son);
        rc(pmrc_pkg::ADDR_FLAGS, son);
        wake = 1'b0;
        pup = 1'b1;
        @(posedge clk);
        #1 pup = 1'b0;
        rc(pmrc_pkg::ADDR_FLAGS, 8'h00);
        wr(pmrc_pkg::ADDR_CTRL, 8'h01);
        wr(pmrc_pkg::ADDR_CTRL, 8'h00);
        check(8'(ncoin), 8'h01);
        rc(pmrc_pkg::ADDR_CTRL, 8'h00);
        pfo_n = 1'b0;
        repeat (4) @(posedge clk);
        #1 check({7'h00, off}, 8'h00);
        check({2'b00, conv}, cv);
        pfo_n = 1'b1;
        wr(pmrc_pkg::ADDR_CTRL, 8'hFE);
        rc(pmrc_pkg::ADDR_CTRL, 8'h02);
        pfo_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 check({7'h00, off}, 8'h01);
        check({2'b00, conv}, seal ? cv & 8'h30 : 8'h00);
        check({4'h0, swo}, 8'h00);
        complete_run();
    end
endmodule : pmrc_rail_control_regs_test
